//--- vic_core_model.sv
// Purpose: Processor core model that accepts grants from the controller
// Assumes: One clock domain, grant level held until acknowledged
// Notes:   Acknowledge delay is set by the bench, from prompt to slow
module vic_core_model (
   input  wire logic                clk_sys_in,
   input  wire logic                nrst_in,
   input  wire vic_pkg::vic_grant_t grant_in,
   input  wire logic [2:0]          ack_delay_in,
   output logic                     int_ack_out
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [2:0] wait_cnt;

   // One-cycle acknowledge after the grant has stood ack_delay_in cycles
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         wait_cnt    <= 3'h0;
         int_ack_out <= 1'b0;
      end else if (int_ack_out) begin
         wait_cnt    <= 3'h0;
         int_ack_out <= 1'b0;
      end else if (grant_in.irq && wait_cnt == ack_delay_in) begin
         int_ack_out <= 1'b1;
      end else if (grant_in.irq) begin
         wait_cnt <= wait_cnt + 3'h1;
      end else begin
         wait_cnt <= 3'h0;
      end
   end
endmodule : vic_core_model

//--- vic_ctrl.sv
// Purpose: Prioritised vectored interrupt controller with Avalon-MM slave
// Assumes: All inputs synchronous to clk_sys_in (25 MHz)
// Notes:   Grant to the core is a level held until int_ack_in
module vic_ctrl #(
   parameter int ADDR_W = 3
) (
   input  wire logic                clk_sys_in,
   input  wire logic                nrst_in,
   input  wire logic                ce_in,
   input  wire vic_pkg::vic_avs_t   avs_in,
   output logic                     avs_waitrequest_out,
   output logic [31:0]              avs_readdata_out,
   input  wire logic [18:0]         periph_evt_in,
   input  wire logic                lv_event_in,
   input  wire logic [4:0]          pins_in,
   input  wire logic                break_in,
   input  wire logic [3:0]          rst_src_in,
   input  wire logic                int_ack_in,
   output vic_pkg::vic_grant_t      grant_out
);

   // ****************************************************************
   // Helpers
   // ****************************************************************
   if (ADDR_W != 3) begin : g_chk
      $error("vic_ctrl serves exactly eight register words");
   end

   function automatic logic [31:0] be_merge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r;
   endfunction : be_merge

   function automatic logic [4:0] first_rank(input logic [18:0] v);
      logic [4:0] r;
      r = 5'h00;
      for (int i = vic_pkg::NUM_SRC - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = 5'(i);
         end
      end
      return r;
   endfunction : first_rank

   // Rank to vector; gaps in the table are skipped
   function automatic logic [15:0] vec_of(input logic [4:0] rank);
      logic [15:0] r;
      case (rank)
         5'h00, 5'h01, 5'h02, 5'h03, 5'h04:
            r = 16'h0004 + 16'({rank, 1'b0});
         5'h05:
            r = 16'h0010;
         5'h06, 5'h07, 5'h08, 5'h09:
            r = 16'h000A + 16'({rank, 1'b0});
         5'h11, 5'h12:
            r = 16'h0018 + 16'({rank, 1'b0});
         default:
            r = 16'h0014 + 16'({rank, 1'b0});
      endcase
      return r;
   endfunction : vec_of

   // ****************************************************************
   // State
   // ****************************************************************
   vic_pkg::vic_state_t s;
   vic_pkg::vic_state_t next_s;
   logic [4:0]          pin_evt;
   logic [18:0]         set_vec;
   logic [18:0]         elig;
   logic [18:0]         hi;
   logic [4:0]          pick;
   logic [31:0]         wmerge;

   always_comb begin
      next_s  = s;
      // Edge select ahead of the request flags
      pin_evt = (pins_in & ~s.pin_prev & s.rise)
              | (~pins_in & s.pin_prev & s.fall);
      set_vec = (periph_evt_in & vic_pkg::PERIPH_SRC)
              | {13'h0000, pin_evt, lv_event_in & s.lvmode};
      wmerge  = 32'h0000_0000;
      elig    = 19'h0_0000;
      hi      = 19'h0_0000;
      pick    = 5'h00;
      if (ce_in) begin
         next_s.pin_prev = pins_in;
         // Bus slave: one wait cycle, then answer
         case (s.bus)
            vic_pkg::VIC_BUS_IDLE: begin
               if (avs_in.read || avs_in.write) begin
                  next_s.bus     = vic_pkg::VIC_BUS_ACK;
                  next_s.waitreq = 1'b0;
                  case (avs_in.address)
                     vic_pkg::IDX_REQ:    next_s.rdata = {13'h0000, s.req};
                     vic_pkg::IDX_MASK:   next_s.rdata = {13'h0000, s.mask};
                     vic_pkg::IDX_PRIO:   next_s.rdata = {13'h0000, s.prio};
                     vic_pkg::IDX_RISE:   next_s.rdata = {27'h000_0000,
                                                          s.rise};
                     vic_pkg::IDX_FALL:   next_s.rdata = {27'h000_0000,
                                                          s.fall};
                     vic_pkg::IDX_PSW:    next_s.rdata = {30'h0000_0000,
                                                          s.in_service_rank_flag, s.ie};
                     vic_pkg::IDX_VDC:    next_s.rdata = {29'h0000_0000,
                                                          s.lvmode, 1'b0};
                     vic_pkg::IDX_STATUS: next_s.rdata = {s.grant.vector,
                                            4'h0, s.grant.irq, s.rst_pend,
                                            s.brk_pend, s.cur, s.rst_cause};
                     default:             next_s.rdata = 32'h0000_0000;
                  endcase
               end
            end
            vic_pkg::VIC_BUS_ACK: begin
               next_s.bus     = vic_pkg::VIC_BUS_IDLE;
               next_s.waitreq = 1'b1;
               if (avs_in.write) begin
                  wmerge = be_merge(s.rdata, avs_in.writedata,
                                    avs_in.byteenable);
                  // Eight register groups under software control
                  case (avs_in.address)
                     vic_pkg::IDX_REQ:    next_s.req  = wmerge[18:0];
                     vic_pkg::IDX_MASK:   next_s.mask = wmerge[18:0];
                     vic_pkg::IDX_PRIO:   next_s.prio = wmerge[18:0];
                     vic_pkg::IDX_RISE:   next_s.rise = wmerge[4:0];
                     vic_pkg::IDX_FALL:   next_s.fall = wmerge[4:0];
                     vic_pkg::IDX_PSW: begin
                        next_s.ie  = wmerge[vic_pkg::PSW_IE_BIT];
                        next_s.in_service_rank_flag = wmerge[vic_pkg::PSW_ISP_BIT];
                     end
                     vic_pkg::IDX_VDC:
                        next_s.lvmode = wmerge[vic_pkg::VDC_MODE_BIT];
                     vic_pkg::IDX_STATUS:
                        next_s.rst_cause = s.rst_cause & ~wmerge[3:0];
                     default: ;
                  endcase
               end
            end
            default: begin
               next_s.bus     = vic_pkg::VIC_BUS_IDLE;
               next_s.waitreq = 1'b1;
            end
         endcase
         // Acknowledge from the core
         if (int_ack_in && s.grant.irq) begin
            case (s.kind)
               vic_pkg::VIC_KIND_MASK: begin
                  next_s.req[s.cur] = 1'b0;
                  next_s.ie         = 1'b0;
                  next_s.in_service_rank_flag        = s.prio[s.cur];
               end
               vic_pkg::VIC_KIND_BRK: begin
                  next_s.brk_pend = 1'b0;
                  next_s.ie       = 1'b0;
               end
               default: next_s.rst_pend = 1'b0;
            endcase
         end
         // Hardware sets win over any clear in the same cycle
         next_s.req = next_s.req | set_vec;
         if (break_in) begin
            next_s.brk_pend = 1'b1;
         end
         if (|rst_src_in) begin
            next_s.rst_pend  = 1'b1;
            next_s.rst_cause = next_s.rst_cause | rst_src_in;
         end
         // Resolution: group first, then fixed rank
         elig = next_s.req & ~next_s.mask & {19{next_s.ie}}
              & (~next_s.prio | {19{next_s.in_service_rank_flag}});
         hi   = elig & ~next_s.prio;
         pick = (|hi) ? first_rank(hi) : first_rank(elig);
         if (next_s.rst_pend) begin
            next_s.kind  = vic_pkg::VIC_KIND_RST;
            next_s.grant = '{irq: 1'b1, high: 1'b1,
                             vector: vic_pkg::VEC_RESET};
         end else if (next_s.brk_pend) begin
            next_s.kind  = vic_pkg::VIC_KIND_BRK;
            next_s.grant = '{irq: 1'b1, high: 1'b1,
                             vector: vic_pkg::VEC_BREAK};
         end else begin
            next_s.kind  = vic_pkg::VIC_KIND_MASK;
            next_s.cur   = pick;
            next_s.grant = '{irq: |elig, high: |hi,
                             vector: vec_of(pick)};
         end
      end
   end

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         s           <= '0;
         s.mask      <= vic_pkg::RST_MASK;
         s.prio      <= vic_pkg::RST_PRIO;
         s.in_service_rank_flag       <= 1'b1;
         s.bus       <= vic_pkg::VIC_BUS_IDLE;
         s.waitreq   <= 1'b1;
         s.kind      <= vic_pkg::VIC_KIND_MASK;
      end else begin
         s <= next_s;
      end
   end

   assign avs_waitrequest_out = s.waitreq;
   assign avs_readdata_out    = s.rdata;
   assign grant_out           = s.grant;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!nrst_in);

   sequence s_bus_req;
      ce_in && (avs_in.read || avs_in.write)
      && s.bus == vic_pkg::VIC_BUS_IDLE;
   endsequence
   sequence s_mask_grant;
      s.grant.irq && s.kind == vic_pkg::VIC_KIND_MASK;
   endsequence

   a_bus_one_wait: assert property (s_bus_req |=> !avs_waitrequest_out
      ##1 (avs_waitrequest_out || !$past(ce_in)))
      else $error("bus answer not one cycle wide");
   a_gap_vectors: assert property (s.grant.irq |-> !(
      s.grant.vector == 16'h000E
      || (s.grant.vector >= 16'h0012 && s.grant.vector <= 16'h0014)
      || (s.grant.vector >= 16'h001E && s.grant.vector <= 16'h0026)
      || (s.grant.vector >= 16'h0036 && s.grant.vector <= 16'h0038)))
      else $error("unused vector issued");
   a_lv_gated: assert property (ce_in && lv_event_in && !s.lvmode
      && !s.req[0] && !avs_in.write |=> !s.req[0])
      else $error("voltage event raised without mode bit");
   a_ack_clears: assert property (s_mask_grant and (ce_in && int_ack_in
      && !set_vec[s.cur] && !avs_in.write) |=> !s.req[$past(s.cur)])
      else $error("acknowledged flag not cleared");
   a_brk_taken: assert property (ce_in && break_in && !s.rst_pend
      && !(|rst_src_in) |=> s.grant.irq
      && s.grant.vector == vic_pkg::VEC_BREAK)
      else $error("break not presented");
   a_rst_vector: assert property (ce_in && |rst_src_in |=> s.grant.irq
      && s.grant.vector == vic_pkg::VEC_RESET)
      else $error("reset source not at vector zero");
   a_pin_rise: assert property (ce_in && pins_in[0] && !s.pin_prev[0]
      && s.rise[0] |=> s.req[1])
      else $error("rising pin edge lost");
   a_mask_blocks: assert property (s_mask_grant |-> !s.mask[s.cur]
      && s.req[s.cur] && s.grant.vector == vec_of(s.cur))
      else $error("masked or idle source granted");
   a_low_nest: assert property (s_mask_grant and s.prio[s.cur]
      |-> s.in_service_rank_flag && s.ie && !s.grant.high)
      else $error("low group granted while blocked");
   a_rank_first: assert property (s_mask_grant |-> ((s.req & ~s.mask
      & ~s.prio & {19{s.prio[s.cur]}}) == 19'h0_0000))
      else $error("high group request passed over");

endmodule : vic_ctrl

//--- vic_ctrl_tb_top.sv
// Purpose: Self-checking bench of the vectored interrupt controller
// Assumes: Avalon answer one cycle after the request is taken
// Notes:   Expected reads and grants are queued, a monitor compares them
module vic_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   // ****************************************************************
   // Signals
   // ****************************************************************
   logic                clk_sys_in;
   logic                nrst_in;
   logic                ce_in;
   vic_pkg::vic_avs_t   avs;
   logic                avs_waitrequest_out;
   logic [31:0]         avs_readdata_out;
   logic [18:0]         periph_evt_in;
   logic                lv_event_in;
   logic [4:0]          pins_in;
   logic                break_in;
   logic [3:0]          rst_src_in;
   logic                int_ack_in;
   vic_pkg::vic_grant_t grant_out;
   logic [2:0]          ack_delay;
   logic [18:0]         ev;
   int                  fails;
   int                  num_checks;
   int                  acks;
   logic [31:0]         rq[$];
   logic [16:0]         gq[$];
   logic [15:0]         vt[19] = '{16'h0004, 16'h0006, 16'h0008, 16'h000A,
      16'h000C, 16'h0010, 16'h0016, 16'h0018, 16'h001A, 16'h001C, 16'h0028,
      16'h002A, 16'h002C, 16'h002E, 16'h0030, 16'h0032, 16'h0034, 16'h003A,
      16'h003C};

   vic_ctrl vic_ctrl_i (
      .clk_sys_in          (clk_sys_in),
      .nrst_in             (nrst_in),
      .ce_in               (ce_in),
      .avs_in              (avs),
      .avs_waitrequest_out (avs_waitrequest_out),
      .avs_readdata_out    (avs_readdata_out),
      .periph_evt_in       (periph_evt_in),
      .lv_event_in         (lv_event_in),
      .pins_in             (pins_in),
      .break_in            (break_in),
      .rst_src_in          (rst_src_in),
      .int_ack_in          (int_ack_in),
      .grant_out           (grant_out)
   );

   vic_core_model vic_core_model_i (
      .clk_sys_in   (clk_sys_in),
      .nrst_in      (nrst_in),
      .grant_in     (grant_out),
      .ack_delay_in (ack_delay),
      .int_ack_out  (int_ack_in)
   );

   // ****************************************************************
   // Tasks
   // ****************************************************************
   function automatic logic rsv(input logic [15:0] v);
      return v == 16'h000E || (v >= 16'h0012 && v <= 16'h0014) ||
         (v >= 16'h001E && v <= 16'h0026) || (v >= 16'h0036 && v <= 16'h0038);
   endfunction : rsv

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic acc(input logic w, input logic [2:0] a,
                      input logic [31:0] d, input logic [3:0] be);
      avs.read       <= !w;
      avs.write      <= w;
      avs.address    <= a;
      avs.writedata  <= d;
      avs.byteenable <= be;
      @(posedge clk_sys_in);
      while (avs_waitrequest_out !== 1'b0) @(posedge clk_sys_in);
      avs.read  <= 1'b0;
      avs.write <= 1'b0;
      @(posedge clk_sys_in);
   endtask : acc

   task automatic wr(input logic [2:0] a, input logic [31:0] d);
      acc(1'b1, a, d, 4'hF);
   endtask : wr

   task automatic rd(input logic [2:0] a, input logic [31:0] e);
      rq.push_back(e);
      acc(1'b0, a, 32'h0000_0000, 4'hF);
   endtask : rd

   task automatic evt(input logic [18:0] e);
      periph_evt_in <= e;
      @(posedge clk_sys_in);
      periph_evt_in <= 19'h0_0000;
      @(posedge clk_sys_in);
   endtask : evt

   task automatic wack();
      int n;
      n = acks;
      while (acks == n) @(posedge clk_sys_in);
      @(posedge clk_sys_in);
   endtask : wack

   task automatic final_report();
      chk(32'(gq.size() + rq.size()), 32'h0000_0000);
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : final_report

   // ****************************************************************
   // Monitor, clock, watchdog
   // ****************************************************************
   always @(posedge clk_sys_in) begin
      if (avs.read && avs_waitrequest_out === 1'b0) begin
         if (rq.size() == 0) chk(32'h0000_0001, 32'h0000_0000);
         else chk(avs_readdata_out, rq.pop_front());
      end
      if (int_ack_in && grant_out.irq === 1'b1) begin
         acks++;
         chk({31'h0, rsv(grant_out.vector)}, 32'h0000_0000);
         if (gq.size() == 0) chk(32'h0000_0001, 32'h0000_0000);
         else chk({15'h0, grant_out.high, grant_out.vector},
                  {15'h0, gq.pop_front()});
      end
   end

   initial begin
      clk_sys_in = 1'b0;
      forever #20 clk_sys_in = ~clk_sys_in;
   end

   initial begin
      repeat (20000) @(posedge clk_sys_in);
      fails++;
      final_report();
   end

   // ****************************************************************
   // Tests
   // ****************************************************************
   initial begin
      nrst_in = 1'b0;
      ce_in = 1'b1;
      avs = '0;
      periph_evt_in = 19'h0_0000;
      lv_event_in = 1'b0;
      pins_in = 5'h00;
      break_in = 1'b0;
      rst_src_in = 4'h0;
      ack_delay = 3'h0;
      void'($urandom(32'hca30_b4f4));
      repeat (3) @(posedge clk_sys_in);
      nrst_in <= 1'b1;
      @(posedge clk_sys_in);
      rd(vic_pkg::IDX_REQ, 32'h0000_0000);
      rd(vic_pkg::IDX_MASK, {13'h0, vic_pkg::RST_MASK});
      rd(vic_pkg::IDX_PRIO, {13'h0, vic_pkg::RST_PRIO});
      rd(vic_pkg::IDX_RISE, 32'h0000_0000);
      rd(vic_pkg::IDX_FALL, 32'h0000_0000);
      rd(vic_pkg::IDX_PSW, 32'h0000_0002);
      rd(vic_pkg::IDX_VDC, 32'h0000_0000);
      acc(1'b1, vic_pkg::IDX_MASK, 32'h0000_0000, 4'h1);
      rd(vic_pkg::IDX_MASK, 32'h0007_FF00);
      $display("test reset and lanes done");
      ack_delay <= 3'($urandom % 8);
      wr(vic_pkg::IDX_MASK, 32'h0000_0000);
      ev = (19'($urandom) & vic_pkg::PERIPH_SRC) | 19'h0_0040;
      evt(ev);
      rd(vic_pkg::IDX_REQ, {13'h0, ev});
      for (int r = 0; r < 19; r++) if (ev[r]) gq.push_back({1'b0, vt[r]});
      for (int r = 0; r < 19; r++) begin
         if (ev[r]) begin
            wr(vic_pkg::IDX_PSW, 32'h0000_0003);
            wack();
         end
      end
      rd(vic_pkg::IDX_REQ, 32'h0000_0000);
      $display("test default order done");
      ack_delay <= 3'h0;
      wr(vic_pkg::IDX_PRIO, 32'h0007_FCFF);
      gq.push_back({1'b1, vt[8]});
      evt(19'h0_0100);
      wr(vic_pkg::IDX_PSW, 32'h0000_0001);
      wack();
      wr(vic_pkg::IDX_PSW, 32'h0000_0001);
      evt(19'h0_0040);
      repeat (8) @(posedge clk_sys_in);
      gq.push_back({1'b1, vt[9]});
      evt(19'h0_0200);
      wack();
      gq.push_back({1'b0, vt[6]});
      wr(vic_pkg::IDX_PSW, 32'h0000_0003);
      wack();
      wr(vic_pkg::IDX_PSW, 32'h0000_0003);
      gq.push_back({1'b1, vt[8]});
      evt(19'h0_0100);
      wack();
      $display("test nesting done");
      wr(vic_pkg::IDX_MASK, 32'h0007_FFFF);
      wr(vic_pkg::IDX_RISE, 32'h0000_0005);
      wr(vic_pkg::IDX_FALL, 32'h0000_0018);
      pins_in <= 5'h1F;
      repeat (3) @(posedge clk_sys_in);
      pins_in <= 5'h00;
      repeat (3) @(posedge clk_sys_in);
      rd(vic_pkg::IDX_REQ, 32'h0000_003A);
      wr(vic_pkg::IDX_REQ, 32'h0000_0000);
      $display("test pin edges done");
      lv_event_in <= 1'b1;
      @(posedge clk_sys_in);
      lv_event_in <= 1'b0;
      repeat (2) @(posedge clk_sys_in);
      rd(vic_pkg::IDX_REQ, 32'h0000_0000);
      wr(vic_pkg::IDX_VDC, 32'h0000_0002);
      lv_event_in <= 1'b1;
      @(posedge clk_sys_in);
      lv_event_in <= 1'b0;
      repeat (2) @(posedge clk_sys_in);
      rd(vic_pkg::IDX_REQ, 32'h0000_0001);
      wr(vic_pkg::IDX_REQ, 32'h0000_0000);
      $display("test voltage event done");
      // Events seen while the clock enable is low must be lost
      ce_in <= 1'b0;
      lv_event_in <= 1'b1;
      pins_in <= 5'h1F;
      @(posedge clk_sys_in);
      lv_event_in <= 1'b0;
      pins_in <= 5'h00;
      @(posedge clk_sys_in);
      ce_in <= 1'b1;
      @(posedge clk_sys_in);
      rd(vic_pkg::IDX_REQ, 32'h0000_0000);
      $display("test clock enable done");
      wr(vic_pkg::IDX_PSW, 32'h0000_0000);
      gq.push_back({1'b1, vic_pkg::VEC_BREAK});
      break_in <= 1'b1;
      @(posedge clk_sys_in);
      break_in <= 1'b0;
      wack();
      for (int i = 0; i < 4; i++) begin
         gq.push_back({1'b1, vic_pkg::VEC_RESET});
         rst_src_in <= 4'(1 << i);
         @(posedge clk_sys_in);
         rst_src_in <= 4'h0;
         wack();
      end
      rd(vic_pkg::IDX_STATUS, 32'h0004_000F);
      wr(vic_pkg::IDX_STATUS, 32'h0000_000F);
      rd(vic_pkg::IDX_STATUS, 32'h0004_0000);
      $display("test break and reset vectors done");
      final_report();
   end
endmodule : vic_ctrl_tb_top

//--- vic_pkg.sv
// Purpose: Shared constants and types of the vectored interrupt controller
// Assumes: 19 maskable ranks, five edge pins, word-indexed register map
// Notes:   Register index n sits at Avalon byte address 4*n
package vic_pkg;

   // ****************************************************************
   // Sizes and register map
   // ****************************************************************
   localparam int          NUM_SRC    = 19;
   localparam int          NUM_PIN    = 5;
   localparam logic [2:0]  IDX_REQ    = 3'h0;
   localparam logic [2:0]  IDX_MASK   = 3'h1;
   localparam logic [2:0]  IDX_PRIO   = 3'h2;
   localparam logic [2:0]  IDX_RISE   = 3'h3;
   localparam logic [2:0]  IDX_FALL   = 3'h4;
   localparam logic [2:0]  IDX_PSW    = 3'h5;
   localparam logic [2:0]  IDX_VDC    = 3'h6;
   localparam logic [2:0]  IDX_STATUS = 3'h7;

   // ****************************************************************
   // Field positions, reset values and source sets
   // ****************************************************************
   localparam int          PSW_IE_BIT   = 0;
   localparam int          PSW_ISP_BIT  = 1;
   localparam int          VDC_MODE_BIT = 1;
   localparam logic [18:0] RST_MASK     = 19'h7_FFFF;
   localparam logic [18:0] RST_PRIO     = 19'h7_FFFF;
   localparam logic [18:0] INT_SRC      = 19'h7_FFC1;
   localparam logic [18:0] PERIPH_SRC   = 19'h7_FFC0;

   // ****************************************************************
   // Vectors
   // ****************************************************************
   localparam logic [15:0] VEC_RESET = 16'h0000;
   localparam logic [15:0] VEC_BREAK = 16'h003E;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [1:0] {
      VIC_BUS_IDLE = 2'b01,
      VIC_BUS_ACK  = 2'b10
   } vic_bus_t;

   typedef enum logic [2:0] {
      VIC_KIND_MASK = 3'b001,
      VIC_KIND_BRK  = 3'b010,
      VIC_KIND_RST  = 3'b100
   } vic_kind_t;

   typedef struct packed {
      logic        read;
      logic        write;
      logic [2:0]  address;
      logic [31:0] writedata;
      logic [3:0]  byteenable;
   } vic_avs_t;

   typedef struct packed {
      logic        irq;
      logic        high;
      logic [15:0] vector;
   } vic_grant_t;

   typedef struct packed {
      logic [18:0] req;
      logic [18:0] mask;
      logic [18:0] prio;
      logic [4:0]  rise;
      logic [4:0]  fall;
      logic [4:0]  pin_prev;
      logic        ie;
      logic        in_service_rank_flag;
      logic        lvmode;
      logic        brk_pend;
      logic        rst_pend;
      logic [3:0]  rst_cause;
      vic_bus_t    bus;
      logic        waitreq;
      logic [31:0] rdata;
      vic_kind_t   kind;
      logic [4:0]  cur;
      vic_grant_t  grant;
   } vic_state_t;

endpackage : vic_pkg
